// file: rtl/ocir_regs.sv
// output configuration and correction seed register bank
`timescale 1ns/1ps
module ocir_regs
  import ocir_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic softReset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [1:0] strapDriver,
  input wire logic [1:0] strapFormat,
  input wire logic [SAMPLE_WIDTH-1:0] sampleIn,
  output logic [7:0] regRdata,
  output logic [2:0] driverMode,
  output logic [2:0] formatMode,
  output logic [SAMPLE_WIDTH-1:0] sampleOut,
  output logic [7:0] acHysteresis,
  output logic [7:0] coarseOffsetSeed,
  output logic [7:0] fineOffsetSeed,
  output logic [7:0] mediumGainSeed,
  output logic [7:0] fineGainSeed,
  output logic [7:0] sampleTimingSeed,
  output logic [7:0] interleaveTimingOffset,
  output logic clockEdgeAdvance
);
  // ==========================================================
  // elaboration check
  // the twos complement path needs a sign bit and one more
  if (SAMPLE_WIDTH < 2) begin : g_width_check
    $error("sample width below two bits");
  end

  // ==========================================================
  // register storage
  // output select and reserved location, both spared by soft reset
  logic [7:0] outSel;
  logic [7:0] next_outSel;
  logic [7:0] rsvdZero;
  logic [7:0] next_rsvdZero;
  // next values of the correction seeds, which are output ports
  logic [7:0] next_acHysteresis;
  logic [7:0] next_coarseOffsetSeed;
  logic [7:0] next_fineOffsetSeed;
  logic [7:0] next_mediumGainSeed;
  logic [7:0] next_fineGainSeed;
  logic [7:0] next_sampleTimingSeed;
  logic [7:0] next_interleaveTimingOffset;
  // clock edge advance register, only its lowest bit is used
  logic [7:0] edgeReg;
  logic [7:0] next_edgeReg;
  // registered outputs
  logic [7:0] next_regRdata;
  logic [2:0] next_driverMode;
  logic [2:0] next_formatMode;
  logic [SAMPLE_WIDTH-1:0] next_sampleOut;
  // sample word in the effective format, one cycle ahead of sampleOut
  logic [SAMPLE_WIDTH-1:0] encoded;

  // ==========================================================
  // decoding helpers
  // driver select field of the output select register
  function automatic logic [2:0] driverField(input logic [7:0] r);
    driverField = r[DRV_MSB:DRV_LSB];
  endfunction

  // data format field of the output select register
  function automatic logic [2:0] formatField(input logic [7:0] r);
    formatField = r[FMT_MSB:FMT_LSB];
  endfunction

  // maps the driver strap pins to a driver code
  function automatic logic [2:0] strapDriverCode(input logic [1:0] s);
    unique case (s)
      STRAP_TWOS: strapDriverCode = OCIR_DRV_LVDS2;
      STRAP_GRAY: strapDriverCode = OCIR_DRV_LVDS3;
      default: strapDriverCode = OCIR_DRV_CMOS;
    endcase
  endfunction

  // maps the format strap pins to a format code
  function automatic logic [2:0] strapFormatCode(input logic [1:0] s);
    unique case (s)
      STRAP_TWOS: strapFormatCode = OCIR_FMT_TWOS;
      STRAP_GRAY: strapFormatCode = OCIR_FMT_GRAY;
      default: strapFormatCode = OCIR_FMT_OBIN;
    endcase
  endfunction

  // ==========================================================
  // write and soft reset next values
  always_comb begin
    next_outSel = outSel;
    next_rsvdZero = rsvdZero;
    next_acHysteresis = acHysteresis;
    next_coarseOffsetSeed = coarseOffsetSeed;
    next_fineOffsetSeed = fineOffsetSeed;
    next_mediumGainSeed = mediumGainSeed;
    next_fineGainSeed = fineGainSeed;
    next_sampleTimingSeed = sampleTimingSeed;
    next_interleaveTimingOffset = interleaveTimingOffset;
    next_edgeReg = edgeReg;
    if (softReset) begin
      // soft reset restores defaults but spares 0x72 and 0x73
      next_acHysteresis = RST_AC_HYST;
      next_coarseOffsetSeed = RST_ZERO;
      next_fineOffsetSeed = RST_ZERO;
      next_mediumGainSeed = RST_MID;
      next_fineGainSeed = RST_MID;
      next_sampleTimingSeed = RST_MID;
      next_interleaveTimingOffset = RST_MID;
      next_edgeReg = RST_ZERO;
      // a write in the same cycle is dropped: the command wins
    end else if (regWrite) begin
      unique case (regAddr)
        ADDR_AC_HYST: next_acHysteresis = regWdata;
        ADDR_COARSE_OFS: next_coarseOffsetSeed = regWdata;
        ADDR_FINE_OFS: next_fineOffsetSeed = regWdata;
        ADDR_MED_GAIN: next_mediumGainSeed = regWdata;
        ADDR_FINE_GAIN: next_fineGainSeed = regWdata;
        ADDR_SAMPLE_TIMING: next_sampleTimingSeed = regWdata;
        ADDR_ILV_TIMING: next_interleaveTimingOffset = regWdata;
        ADDR_EDGE_ADV: next_edgeReg = regWdata;
        ADDR_RSVD_ZERO: next_rsvdZero = regWdata;
        ADDR_OUT_SEL: next_outSel = regWdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // effective mode decode and read data
  always_comb begin
    // pin control code takes the strap pins, any other code passes
    next_driverMode = driverField(outSel);
    if (driverField(outSel) == OCIR_DRV_PIN) begin
      next_driverMode = strapDriverCode(strapDriver);
    end
    next_formatMode = formatField(outSel);
    if (formatField(outSel) == OCIR_FMT_PIN) begin
      next_formatMode = strapFormatCode(strapFormat);
    end
    // a read and a write in one cycle return the old contents
    next_regRdata = regRdata;
    if (regRead) begin
      unique case (regAddr)
        ADDR_AC_HYST: next_regRdata = acHysteresis;
        ADDR_COARSE_OFS: next_regRdata = coarseOffsetSeed;
        ADDR_FINE_OFS: next_regRdata = fineOffsetSeed;
        ADDR_MED_GAIN: next_regRdata = mediumGainSeed;
        ADDR_FINE_GAIN: next_regRdata = fineGainSeed;
        ADDR_SAMPLE_TIMING: next_regRdata = sampleTimingSeed;
        ADDR_ILV_TIMING: next_regRdata = interleaveTimingOffset;
        ADDR_EDGE_ADV: next_regRdata = edgeReg;
        ADDR_RSVD_ZERO: next_regRdata = rsvdZero;
        ADDR_OUT_SEL: next_regRdata = outSel;
        default: next_regRdata = RST_ZERO;
      endcase
    end
    // formatted sample is registered so the output comes from a flop
    next_sampleOut = encoded;
  end

  // sample formatting in the selected code
  ocir_sample_encoder #(
    .WIDTH(SAMPLE_WIDTH)
  ) u_enc (
    .sampleIn(sampleIn),
    .formatSel(formatMode),
    .sampleOut(encoded)
  );

  // ==========================================================
  // state registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      outSel <= RST_ZERO;
      rsvdZero <= RST_ZERO;
      acHysteresis <= RST_AC_HYST;
      coarseOffsetSeed <= RST_ZERO;
      fineOffsetSeed <= RST_ZERO;
      mediumGainSeed <= RST_MID;
      fineGainSeed <= RST_MID;
      sampleTimingSeed <= RST_MID;
      interleaveTimingOffset <= RST_MID;
      edgeReg <= RST_ZERO;
      regRdata <= RST_ZERO;
      driverMode <= OCIR_DRV_PIN;
      formatMode <= OCIR_FMT_PIN;
      sampleOut <= '0;
      clockEdgeAdvance <= 1'b0;
      // clkEn low below holds every flip-flop, outputs included
    end else if (clkEn) begin
      outSel <= next_outSel;
      rsvdZero <= next_rsvdZero;
      acHysteresis <= next_acHysteresis;
      coarseOffsetSeed <= next_coarseOffsetSeed;
      fineOffsetSeed <= next_fineOffsetSeed;
      mediumGainSeed <= next_mediumGainSeed;
      fineGainSeed <= next_fineGainSeed;
      sampleTimingSeed <= next_sampleTimingSeed;
      interleaveTimingOffset <= next_interleaveTimingOffset;
      edgeReg <= next_edgeReg;
      regRdata <= next_regRdata;
      driverMode <= next_driverMode;
      formatMode <= next_formatMode;
      sampleOut <= next_sampleOut;
      clockEdgeAdvance <= next_edgeReg[EDGE_BIT];
    end
  end
endmodule

// file: rtl/ocir_pkg.sv
// package: register map and field codes of the output and seed registers
package ocir_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_AC_HYST = 8'h55;
  localparam logic [7:0] ADDR_COARSE_OFS = 8'h60;
  localparam logic [7:0] ADDR_FINE_OFS = 8'h61;
  localparam logic [7:0] ADDR_MED_GAIN = 8'h62;
  localparam logic [7:0] ADDR_FINE_GAIN = 8'h63;
  localparam logic [7:0] ADDR_SAMPLE_TIMING = 8'h64;
  localparam logic [7:0] ADDR_ILV_TIMING = 8'h70;
  localparam logic [7:0] ADDR_EDGE_ADV = 8'h71;
  localparam logic [7:0] ADDR_RSVD_ZERO = 8'h72;
  localparam logic [7:0] ADDR_OUT_SEL = 8'h73;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MID = 8'h80;
  localparam logic [7:0] RST_AC_HYST = 8'h10;
  // ==========================================================
  // field positions in the output select and edge advance registers
  localparam int DRV_MSB = 6;
  localparam int DRV_LSB = 4;
  localparam int FMT_MSB = 2;
  localparam int FMT_LSB = 0;
  localparam int EDGE_BIT = 0;
  // ==========================================================
  // driver select codes
  typedef enum logic [2:0] {
    OCIR_DRV_PIN = 3'h0,
    OCIR_DRV_LVDS2 = 3'h1,
    OCIR_DRV_LVDS3 = 3'h2,
    OCIR_DRV_CMOS = 3'h4
  } ocir_drv_t;
  // format codes
  typedef enum logic [2:0] {
    OCIR_FMT_PIN = 3'h0,
    OCIR_FMT_TWOS = 3'h1,
    OCIR_FMT_GRAY = 3'h2,
    OCIR_FMT_OBIN = 3'h4
  } ocir_fmt_t;
  // strap pin encodings of format and driver
  localparam logic [1:0] STRAP_TWOS = 2'h0;
  localparam logic [1:0] STRAP_GRAY = 2'h1;
  localparam logic [1:0] STRAP_OBIN = 2'h2;
endpackage

// file: rtl/ocir_sample_encoder.sv
// sample encoder: turns an offset binary word into the chosen format
`timescale 1ns/1ps
module ocir_sample_encoder
  import ocir_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] sampleIn,
  input wire logic [2:0] formatSel,
  output logic [WIDTH-1:0] sampleOut
);
  // elaboration check: the sign bit and one more are needed
  if (WIDTH < 2) begin : g_width_check
    $error("encoder width below two bits");
  end

  // ==========================================================
  // format conversion
  always_comb begin
    unique case (formatSel)
      OCIR_FMT_TWOS: begin
        sampleOut = {~sampleIn[WIDTH-1], sampleIn[WIDTH-2:0]};
      end
      OCIR_FMT_GRAY: begin
        sampleOut = sampleIn ^ (sampleIn >> 1);
      end
      default: begin
        sampleOut = sampleIn; // offset binary
      end
    endcase
  end
endmodule

// file: verif/ocir_regs_chk.sv
// checker: port-level assertions of the output and seed registers
`timescale 1ns/1ps
module ocir_regs_chk
  import ocir_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic softReset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [2:0] driverMode,
  input wire logic [2:0] formatMode,
  input wire logic [7:0] mediumGainSeed,
  input wire logic [7:0] fineGainSeed,
  input wire logic [7:0] sampleTimingSeed,
  input wire logic [7:0] interleaveTimingOffset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // helper: an accepted write to the output select register
  logic outWr;
  assign outWr = clkEn && regWrite && regAddr == ADDR_OUT_SEL && !softReset;
  // ==========================================================
  // assertions
  a_drv_code_follows: assert property (
    outWr && regWdata[6:4] inside {3'h1, 3'h2, 3'h4} ##1 clkEn
    |=> driverMode == $past(regWdata[6:4], 2))
    else $error("driver mode differs from written code");
  a_fmt_code_follows: assert property (
    outWr && regWdata[2:0] inside {3'h1, 3'h2, 3'h4} ##1 clkEn
    |=> formatMode == $past(regWdata[2:0], 2))
    else $error("format mode differs from written code");
  a_strap_resolved: assert property (
    $past(resetn, 2) && $past(resetn)
    |-> driverMode != 3'h0 && formatMode != 3'h0)
    else $error("pin control code left unresolved");
  a_soft_keeps_mode: assert property (
    clkEn && softReset && !regWrite
    |-> ##2 driverMode == $past(driverMode, 2))
    else $error("soft reset changed the output mode");
  a_soft_seeds_mid: assert property (
    clkEn && softReset |=> mediumGainSeed == RST_MID &&
    fineGainSeed == RST_MID && sampleTimingSeed == RST_MID &&
    interleaveTimingOffset == RST_MID)
    else $error("seed not mid-scale after soft reset");
  // main scenarios
  c_out_write: cover property (outWr);
  c_soft_reset: cover property (clkEn && softReset);
  c_gray_mode: cover property (formatMode == 3'h2);
endmodule

bind ocir_regs ocir_regs_chk u_chk (.clk, .resetn, .clkEn, .softReset,
  .regWrite, .regAddr, .regWdata, .driverMode, .formatMode,
  .mediumGainSeed, .fineGainSeed, .sampleTimingSeed,
  .interleaveTimingOffset);

// file: verif/ocir_host.sv
// host model: register writes and reads on the register port
`timescale 1ns/1ps
module ocir_host
  import ocir_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] regRdata,
  output logic regWrite = 1'b0,
  output logic regRead = 1'b0,
  output logic [7:0] regAddr = 8'hff,
  output logic [7:0] regWdata = 8'hff
);
  // writable bits of a register; reserved bits and places get zero
  function automatic logic [7:0] rsvdMask(input logic [7:0] a);
    case (a)
      ADDR_RSVD_ZERO: rsvdMask = 8'h00;
      ADDR_OUT_SEL: rsvdMask = 8'h77;
      ADDR_EDGE_ADV: rsvdMask = 8'h01;
      default: rsvdMask = 8'hff;
    endcase
  endfunction
  // one write strobe; reserved bits and places only ever get zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d & rsvdMask(a);
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a; // released lines show no stale value
    regWdata <= ~d;
  endtask
  // one read strobe; data taken after the edge that accepts it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdata;
  endtask
endmodule

// file: verif/ocir_regs_tb.sv
// testbench: output select and seed register bank
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module ocir_regs_tb
  import ocir_pkg::*;
;
  logic clk = 0, resetn = 0, clkEn = 1, softReset = 0;
  logic [1:0] strapDriver = 0, strapFormat = 0;
  logic [11:0] sampleIn = 12'h9a5, sampleOut;
  logic regWrite, regRead, clockEdgeAdvance;
  logic [7:0] regAddr, regWdata, regRdata, rv, coarseOffsetSeed;
  logic [7:0] mediumGainSeed, fineGainSeed, sampleTimingSeed;
  logic [7:0] interleaveTimingOffset, acHysteresis, fineOffsetSeed;
  logic [2:0] driverMode, formatMode;
  logic [2:0] codes [3] = '{3'h1, 3'h2, 3'h4};
  logic [2:0] strapMap [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
  int fails = 0, n_tests = 0;
  // clock and parts
  always #10 clk = ~clk;
  ocir_regs u_ocir_regs (.clk, .resetn, .clkEn, .softReset, .regWrite,
    .regRead, .regAddr, .regWdata, .strapDriver, .strapFormat, .sampleIn,
    .regRdata, .driverMode, .formatMode, .sampleOut, .acHysteresis,
    .coarseOffsetSeed, .fineOffsetSeed, .mediumGainSeed, .fineGainSeed,
    .sampleTimingSeed, .interleaveTimingOffset, .clockEdgeAdvance);
  ocir_host u_ocir_host (.clk, .regRdata, .regWrite, .regRead, .regAddr,
    .regWdata);
  // ==========================================================
  // expected sample coding from offset binary
  function automatic logic [11:0] enc(logic [2:0] f, logic [11:0] s);
    case (f)
      3'h1: enc = {~s[11], s[10:0]};
      3'h2: enc = s ^ (s >> 1);
      default: enc = s;
    endcase
  endfunction
  task automatic summarize();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // gain and timing seeds start at mid-scale, offset seeds and output select at zero
  task automatic t_reset();
    #1;
    `CHK(mediumGainSeed, RST_MID)
    `CHK(fineGainSeed, RST_MID)
    `CHK(sampleTimingSeed, RST_MID)
    `CHK(interleaveTimingOffset, RST_MID)
    `CHK(acHysteresis, RST_AC_HYST)
    `CHK(coarseOffsetSeed, RST_ZERO)
    `CHK(fineOffsetSeed, RST_ZERO)
    `CHK(clockEdgeAdvance, 1'b0)
    u_ocir_host.rd(ADDR_OUT_SEL, rv);
    `CHK(rv, RST_ZERO)
  endtask
  // every legal driver and format code, sample coding follows
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      u_ocir_host.wr(ADDR_OUT_SEL, {1'b0, codes[i], 1'b0, codes[2 - i]});
      repeat (3) @(posedge clk);
      #1;
      `CHK(driverMode, codes[i])
      `CHK(formatMode, codes[2 - i])
      `CHK(sampleOut, enc(codes[2 - i], sampleIn))
    end
  endtask
  // pin control codes take the strap pins
  task automatic t_strap();
    u_ocir_host.wr(ADDR_OUT_SEL, RST_ZERO);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      strapDriver <= 2'(s);
      strapFormat <= 2'(3 - s);
      repeat (3) @(posedge clk);
      #1;
      `CHK(driverMode, strapMap[s])
      `CHK(formatMode, strapMap[3 - s])
      `CHK(sampleOut, enc(strapMap[3 - s], sampleIn))
    end
  endtask
  // soft reset keeps output select, returns medium gain seed to mid-scale and coarse offset seed to zero
  task automatic t_soft();
    u_ocir_host.wr(ADDR_OUT_SEL, 8'h21);
    u_ocir_host.wr(ADDR_MED_GAIN, 8'h5a);
    u_ocir_host.wr(ADDR_COARSE_OFS, 8'h33);
    u_ocir_host.wr(ADDR_EDGE_ADV, 8'h01);
    u_ocir_host.wr(ADDR_RSVD_ZERO, 8'h3c);
    #1;
    `CHK(mediumGainSeed, 8'h5a)
    `CHK(coarseOffsetSeed, 8'h33)
    `CHK(clockEdgeAdvance, 1'b1)
    u_ocir_host.rd(ADDR_MED_GAIN, rv);
    `CHK(rv, 8'h5a)
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    u_ocir_host.rd(ADDR_OUT_SEL, rv);
    `CHK(rv, 8'h21)
    `CHK(mediumGainSeed, RST_MID)
    `CHK(coarseOffsetSeed, RST_ZERO)
    `CHK(clockEdgeAdvance, 1'b0)
  endtask
  // clock enable low freezes the bank: a write then is refused
  task automatic t_freeze();
    @(posedge clk);
    clkEn <= 1'b0;
    u_ocir_host.wr(ADDR_MED_GAIN, 8'h11);
    @(posedge clk);
    clkEn <= 1'b1;
    #1;
    `CHK(mediumGainSeed, RST_MID)
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_modes();
    t_strap();
    t_soft();
    t_freeze();
    summarize();
  end
  // watchdog
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
